// ---- include/sbs_pkg.sv ----
package sbs_pkg;
   // array geometry
   localparam int ADDR_W = 19;
   localparam int LANES = 4;
   localparam int BYTE_W = 8;
   localparam int LANE_W = BYTE_W + 1;
   localparam int DATA_W = LANES * LANE_W;
   localparam int PIN_W = LANES * BYTE_W;
   localparam int BURST_W = 2;
   localparam int MEM_DEPTH = 2 ** ADDR_W;
   // write queue entry: address, lane mask, data
   localparam int WQ_DEPTH = 8;
   localparam int WQ_W = ADDR_W + LANES + DATA_W;
   localparam int WQ_DATA_LSB = 0;
   localparam int WQ_MASK_LSB = DATA_W;
   localparam int WQ_ADDR_LSB = DATA_W + LANES;
   // strap level that selects interleaved order
   localparam logic STRAP_INTERLEAVE = 1'b1;
   // selection state, gray coded along idle -> first -> active
   typedef enum logic [1:0] {
      SBS_DESEL = 2'b00,
      SBS_FIRST = 2'b01,
      SBS_ACTIVE = 2'b11
   } sbs_state_e;
endpackage : sbs_pkg

// ---- hw/sbs_burst_counter.sv ----
`timescale 1ns/1ps
module sbs_burst_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // control
   input wire logic load,
   input wire logic advance,
   input wire logic interleave,
   input wire logic [sbs_pkg::BURST_W-1:0] startLow,
   // burst low address bits, value after this edge
   output logic [sbs_pkg::BURST_W-1:0] lowNext
);
   logic [sbs_pkg::BURST_W-1:0] start_reg;
   logic [sbs_pkg::BURST_W-1:0] start_next;
   logic [sbs_pkg::BURST_W-1:0] count_reg;
   logic [sbs_pkg::BURST_W-1:0] count_next;

   // load start, step count, wrap inside four beats
   always_comb begin
      start_next = start_reg;
      count_next = count_reg;
      if (load) begin
         start_next = startLow;
         count_next = '0;
      end else if (advance) begin
         count_next = count_reg + 1'b1;
      end
      if (interleave) begin
         lowNext = start_next ^ count_next;
      end else begin
         lowNext = start_next + count_next;
      end
   end

   // registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         start_reg <= '0;
         count_reg <= '0;
      end else begin
         start_reg <= start_next;
         count_reg <= count_next;
      end
   end
endmodule : sbs_burst_counter

// ---- hw/sbs_fifo.sv ----
`timescale 1ns/1ps
module sbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [PTR_W-1:0] wrPtr_reg;
   logic [PTR_W-1:0] wrPtr_next;
   logic [PTR_W-1:0] rdPtr_reg;
   logic [PTR_W-1:0] rdPtr_next;
   logic [PTR_W:0] count_reg;
   logic [PTR_W:0] count_next;
   logic push;
   logic pop;

   // handshake and pointer update
   always_comb begin
      inReady = (count_reg < (PTR_W+1)'(DEPTH));
      outValid = (count_reg != '0);
      push = inValid && inReady;
      pop = outValid && outReady;
      outData = store[rdPtr_reg];
      wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_next = count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
   end

   // storage and pointers
   always_ff @(posedge sys_clk) begin
      if (push) begin
         store[wrPtr_reg] <= inData;
      end
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end
endmodule : sbs_fifo

// ---- hw/sbs_sram_port.sv ----
`timescale 1ns/1ps
// Contract
// - all synchronous inputs are captured only at the rising edge of sys_clk.
// - the address register loads only on a strobe edge where all chip selects are active.
// - a load copies the two low address bits into the burst counter.
// - a low advance input during a burst steps the counter, otherwise it holds.
// - the device is selected only with first select low, second high, third low.
// - the processor strobe is ignored while the first chip select is high.
// - chip selects are looked at only on address load edges.
// - each of four low lane selects writes its lane when the byte qualifier is low.
// - a low all-lanes write input writes every lane regardless of the lane controls.
// - a low output enable drives the data pins without waiting for a clock.
// - a high output enable floats the data pins so they carry write data.
// - in the first clock of a read after deselect the pins stay undriven.
// - with both strobes low they act alike, and the controller strobe still deselects while the first chip select is high.
// - a low strap gives linear burst order, a high strap interleaved order.
// - the pins float during write data and while deselected, whatever the enable.
module sbs_sram_port (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // address and strobes
   input wire logic [sbs_pkg::ADDR_W-1:0] address,
   input wire logic processorAddressStrobeN,
   input wire logic controllerAddressStrobeN,
   input wire logic burstAdvanceN,
   // chip selects
   input wire logic chipSelectFirstN,
   input wire logic chipSelectSecond,
   input wire logic chipSelectThirdN,
   // write controls
   input wire logic byteWriteQualifierN,
   input wire logic [sbs_pkg::LANES-1:0] laneWriteSelectN,
   input wire logic allLanesWriteN,
   // output enable and burst order strap
   input wire logic outputEnableN,
   input wire logic burstOrderStrap,
   // shared data pins, split into in / out / enable
   input wire logic [sbs_pkg::PIN_W-1:0] dataPinsIn,
   output logic [sbs_pkg::PIN_W-1:0] dataPinsOut,
   output logic dataPinsOe,
   input wire logic [sbs_pkg::LANES-1:0] sharedParityPinsIn,
   output logic [sbs_pkg::LANES-1:0] sharedParityPinsOut,
   output logic sharedParityPinsOe,
   // write queue back-pressure
   output logic writeQueueReady
);
   // state
   sbs_pkg::sbs_state_e state_reg;
   sbs_pkg::sbs_state_e state_next;
   logic [sbs_pkg::ADDR_W-1:0] addr_reg;
   logic [sbs_pkg::ADDR_W-1:0] addr_next;
   logic writeData_reg;
   logic writeData_next;
   logic [sbs_pkg::DATA_W-1:0] rdData_reg;
   logic [sbs_pkg::DATA_W-1:0] rdData_next;

   // decode
   logic procStrobe;
   logic ctrlStrobe;
   logic loadEdge;
   logic csActive;
   logic loadSel;
   logic inBurst;
   logic advance;
   logic interleave;
   logic [sbs_pkg::BURST_W-1:0] lowNext;
   logic [sbs_pkg::ADDR_W-1:0] effAddr;
   logic [sbs_pkg::LANES-1:0] laneMask;
   logic writeEdge;
   logic readEdge;
   logic [sbs_pkg::DATA_W-1:0] pinData;

   // write queue signals
   logic [sbs_pkg::WQ_W-1:0] wqIn;
   logic [sbs_pkg::WQ_W-1:0] wqOut;
   logic wqInValid;
   logic wqOutValid;
   logic wqOutReady;
   logic [sbs_pkg::ADDR_W-1:0] wqAddr;
   logic [sbs_pkg::LANES-1:0] wqMask;
   logic [sbs_pkg::DATA_W-1:0] wqData;
   logic wqPop;
   logic [sbs_pkg::DATA_W-1:0] bankRead;

   // strobe qualification and chip select decode
   always_comb begin
      procStrobe = !processorAddressStrobeN && !chipSelectFirstN;
      ctrlStrobe = !controllerAddressStrobeN;
      loadEdge = procStrobe || ctrlStrobe;
      // selects only matter on a load edge
      csActive = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
      loadSel = loadEdge && csActive;
      inBurst = (state_reg != sbs_pkg::SBS_DESEL);
      advance = !loadEdge && inBurst && !burstAdvanceN;
      interleave = (burstOrderStrap == sbs_pkg::STRAP_INTERLEAVE);
   end

   // burst counter
   sbs_burst_counter sbs_burst_counter_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .load(loadSel),
      .advance(advance),
      .interleave(interleave),
      .startLow(address[sbs_pkg::BURST_W-1:0]),
      .lowNext(lowNext)
   );

   // per-lane write mask
   genvar gi;
   generate
      for (gi = 0; gi < sbs_pkg::LANES; gi++) begin : g_lane
         assign laneMask[gi] = !allLanesWriteN
            || (!byteWriteQualifierN && !laneWriteSelectN[gi]);
      end
   endgenerate

   // pin data gathered into lanes of byte plus parity
   generate
      for (gi = 0; gi < sbs_pkg::LANES; gi++) begin : g_pack
         assign pinData[gi*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] =
            {sharedParityPinsIn[gi], dataPinsIn[gi*sbs_pkg::BYTE_W +: sbs_pkg::BYTE_W]};
      end
   endgenerate

   // next address: load, or burst step with upper bits held
   always_comb begin
      addr_next = addr_reg;
      if (loadSel) begin
         addr_next = address;
      end else if (inBurst) begin
         // upper bits held, low bits from counter
         addr_next = {addr_reg[sbs_pkg::ADDR_W-1:sbs_pkg::BURST_W], lowNext};
      end
      effAddr = addr_next;
   end

   // address register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_reg <= '0;
      end else begin
         addr_reg <= addr_next;
      end
   end

   // next selection state, selects looked at only on a load
   always_comb begin
      state_next = state_reg;
      if (loadEdge) begin
         if (!csActive) begin
            state_next = sbs_pkg::SBS_DESEL;
         end else begin
            case (state_reg)
               sbs_pkg::SBS_DESEL: state_next = sbs_pkg::SBS_FIRST;
               sbs_pkg::SBS_FIRST: state_next = sbs_pkg::SBS_ACTIVE;
               sbs_pkg::SBS_ACTIVE: state_next = sbs_pkg::SBS_ACTIVE;
               default: state_next = sbs_pkg::SBS_DESEL;
            endcase
         end
      end else begin
         case (state_reg)
            sbs_pkg::SBS_DESEL: state_next = sbs_pkg::SBS_DESEL;
            sbs_pkg::SBS_FIRST: state_next = sbs_pkg::SBS_ACTIVE;
            sbs_pkg::SBS_ACTIVE: state_next = sbs_pkg::SBS_ACTIVE;
            default: state_next = sbs_pkg::SBS_DESEL;
         endcase
      end
   end

   // selection state register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= sbs_pkg::SBS_DESEL;
      end else begin
         state_reg <= state_next;
      end
   end

   // access kind of this edge and write phase next
   always_comb begin
      writeEdge = (state_next != sbs_pkg::SBS_DESEL) && (laneMask != '0);
      readEdge = (state_next != sbs_pkg::SBS_DESEL) && !writeEdge;
      writeData_next = writeEdge;
   end

   // write phase register, masks the pins for one clock
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         writeData_reg <= 1'b0;
      end else begin
         writeData_reg <= writeData_next;
      end
   end

   // write queue entry, captured at the edge
   always_comb begin
      wqInValid = writeEdge;
      wqIn = '0;
      wqIn[sbs_pkg::WQ_ADDR_LSB +: sbs_pkg::ADDR_W] = effAddr;
      wqIn[sbs_pkg::WQ_MASK_LSB +: sbs_pkg::LANES] = laneMask;
      wqIn[sbs_pkg::WQ_DATA_LSB +: sbs_pkg::DATA_W] = pinData;
   end

   // queue head unpacked; array port is shared, reads stall draining
   always_comb begin
      wqAddr = wqOut[sbs_pkg::WQ_ADDR_LSB +: sbs_pkg::ADDR_W];
      wqMask = wqOut[sbs_pkg::WQ_MASK_LSB +: sbs_pkg::LANES];
      wqData = wqOut[sbs_pkg::WQ_DATA_LSB +: sbs_pkg::DATA_W];
      wqOutReady = !readEdge;
      wqPop = wqOutValid && wqOutReady;
   end

   sbs_fifo #(
      .WIDTH(sbs_pkg::WQ_W),
      .DEPTH(sbs_pkg::WQ_DEPTH)
   ) sbs_fifo_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .inValid(wqInValid),
      .inReady(writeQueueReady),
      .inData(wqIn),
      .outValid(wqOutValid),
      .outReady(wqOutReady),
      .outData(wqOut)
   );

   // read data for the addressed word, shown after the edge
   always_comb begin
      rdData_next = rdData_reg;
      if (readEdge) begin
         rdData_next = bankRead;
      end
   end

   // one storage bank per lane, written from the queue under its mask
   generate
      for (gi = 0; gi < sbs_pkg::LANES; gi++) begin : g_bank
         logic [sbs_pkg::LANE_W-1:0] bank [0:sbs_pkg::MEM_DEPTH-1];
         always_ff @(posedge sys_clk) begin
            if (wqPop && wqMask[gi]) begin
               bank[wqAddr] <= wqData[gi*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
            end
         end
         assign bankRead[gi*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] = bank[effAddr];
      end
   endgenerate

   // read data register
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdData_reg <= '0;
      end else begin
         rdData_reg <= rdData_next;
      end
   end

   // pin drivers, enable follows output enable without a clock
   always_comb begin
      dataPinsOe = !outputEnableN
         && (state_reg == sbs_pkg::SBS_ACTIVE)
         && !writeData_reg;
      sharedParityPinsOe = dataPinsOe;
   end

   // unpack read data onto the pins
   generate
      for (gi = 0; gi < sbs_pkg::LANES; gi++) begin : g_out
         assign dataPinsOut[gi*sbs_pkg::BYTE_W +: sbs_pkg::BYTE_W] =
            rdData_reg[gi*sbs_pkg::LANE_W +: sbs_pkg::BYTE_W];
         assign sharedParityPinsOut[gi] =
            rdData_reg[gi*sbs_pkg::LANE_W + sbs_pkg::BYTE_W];
      end
   endgenerate
endmodule : sbs_sram_port

// ---- verif/sbs_sram_port_properties.sv ----
`timescale 1ns/1ps
module sbs_sram_port_properties (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // strobes and selects
   input wire logic processorAddressStrobeN,
   input wire logic controllerAddressStrobeN,
   input wire logic burstAdvanceN,
   input wire logic chipSelectFirstN,
   input wire logic chipSelectSecond,
   input wire logic chipSelectThirdN,
   // write controls and enable
   input wire logic byteWriteQualifierN,
   input wire logic [sbs_pkg::LANES-1:0] laneWriteSelectN,
   input wire logic allLanesWriteN,
   input wire logic outputEnableN,
   // data pins
   input wire logic [sbs_pkg::PIN_W-1:0] dataPinsOut,
   input wire logic dataPinsOe
);
   logic ld;
   logic sel;
   logic noWr;
   // decoded edge kinds
   assign ld = (!processorAddressStrobeN && !chipSelectFirstN) || !controllerAddressStrobeN;
   assign sel = !chipSelectFirstN && chipSelectSecond && !chipSelectThirdN;
   assign noWr = allLanesWriteN && (byteWriteQualifierN || (&laneWriteSelectN));
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_oe_high_float: assert property (outputEnableN |-> !dataPinsOe)
      else $error("pins driven with enable high");
   a_desel_float: assert property (ld && !sel |=> !dataPinsOe)
      else $error("pins driven while deselected");
   a_write_float: assert property (ld && sel && !noWr |=> !dataPinsOe)
      else $error("pins driven after write");
   a_first_masked: assert property ((ld && !sel) ##1 (ld && sel && noWr) |=> !dataPinsOe)
      else $error("pins driven in first read clock");
   a_oe_follows: assert property ((ld && sel && noWr) ##1 (!ld && noWr)
      |=> dataPinsOe == !outputEnableN)
      else $error("pins not following enable");
   a_hold_burst: assert property (dataPinsOe && !ld && burstAdvanceN && noWr
      |=> $stable(dataPinsOut))
      else $error("burst moved without advance");
   a_ce_ignored: assert property ((dataPinsOe && !ld && !sel && noWr)
      ##1 !outputEnableN |-> dataPinsOe)
      else $error("selects acted on outside a load");
   a_proc_ignored: assert property ((dataPinsOe && !processorAddressStrobeN
      && chipSelectFirstN && controllerAddressStrobeN && noWr) ##1 !outputEnableN
      |-> dataPinsOe)
      else $error("processor strobe acted on");
endmodule : sbs_sram_port_properties

bind sbs_sram_port sbs_sram_port_properties sbs_sram_port_properties_i (
   .sys_clk(sys_clk),
   .rst(rst),
   .processorAddressStrobeN(processorAddressStrobeN),
   .controllerAddressStrobeN(controllerAddressStrobeN),
   .burstAdvanceN(burstAdvanceN),
   .chipSelectFirstN(chipSelectFirstN),
   .chipSelectSecond(chipSelectSecond),
   .chipSelectThirdN(chipSelectThirdN),
   .byteWriteQualifierN(byteWriteQualifierN),
   .laneWriteSelectN(laneWriteSelectN),
   .allLanesWriteN(allLanesWriteN),
   .outputEnableN(outputEnableN),
   .dataPinsOut(dataPinsOut),
   .dataPinsOe(dataPinsOe)
);

// ---- verif/sbs_host_model.sv ----
`timescale 1ns/1ps
module sbs_host_model (
   // clock
   input wire logic sys_clk,
   // device side
   input wire logic [sbs_pkg::DATA_W-1:0] devOut,
   input wire logic devOe,
   // host side
   input wire logic hostDrive,
   input wire logic [sbs_pkg::DATA_W-1:0] hostData,
   output logic [sbs_pkg::DATA_W-1:0] wireLevel
);
   logic [sbs_pkg::DATA_W-1:0] lastReg;
   // resolved pins; a released bus shows the inverse of its last level
   always_comb begin
      if (devOe) wireLevel = devOut;
      else if (hostDrive) wireLevel = hostData;
      else wireLevel = ~lastReg;
   end
   // last level seen on the pins
   always_ff @(posedge sys_clk) lastReg <= wireLevel;
endmodule : sbs_host_model

// ---- verif/sync_burst_sram_port_bench.sv ----
`timescale 1ns/1ps
module sync_burst_sram_port_bench;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [18:0] address = '0;
   logic pStrobeN = 1'b1, cStrobeN = 1'b1, advN = 1'b1, sel1N = 1'b1, sel2 = 1'b0;
   logic sel3N = 1'b1, gwN = 1'b1, bqN = 1'b1, oeN = 1'b1, strap = 1'b0, hostDrive = 1'b1;
   logic [3:0] laneN = 4'hf;
   logic [35:0] hostData = 36'h0, wireLevel, devOut, pendData = 36'h0;
   logic devOe, parOe, qReady;
   logic [2:0] pend = 3'h0;
   logic [35:0] mem [int];
   int n_errors = 0, total_checks = 0, cyc = 0;
   // device and host
   sbs_sram_port sbs_sram_port_i (.sys_clk(sys_clk), .rst(rst), .address(address),
      .processorAddressStrobeN(pStrobeN), .controllerAddressStrobeN(cStrobeN),
      .burstAdvanceN(advN), .chipSelectFirstN(sel1N), .chipSelectSecond(sel2),
      .chipSelectThirdN(sel3N), .byteWriteQualifierN(bqN), .laneWriteSelectN(laneN),
      .allLanesWriteN(gwN), .outputEnableN(oeN), .burstOrderStrap(strap),
      .dataPinsIn(wireLevel[31:0]), .dataPinsOut(devOut[31:0]), .dataPinsOe(devOe),
      .sharedParityPinsIn(wireLevel[35:32]), .sharedParityPinsOut(devOut[35:32]),
      .sharedParityPinsOe(parOe), .writeQueueReady(qReady));
   sbs_host_model sbs_host_model_i (.sys_clk(sys_clk), .devOut(devOut), .devOe(devOe),
      .hostDrive(hostDrive), .hostData(hostData), .wireLevel(wireLevel));
   // clock and hang guard
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         finish_test();
      end
   end
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task automatic check(input logic [35:0] got, input logic [35:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [12:0] ctl(input logic p, cs, burst_advance_n, s1, s2, s3, gw, bq,
         input logic [3:0] ln, input logic oe);
      return {p, cs, burst_advance_n, s1, s2, s3, gw, bq, ln, oe};
   endfunction : ctl
   // address of burst beat n
   function automatic logic [18:0] eff(input logic [18:0] a, input logic [1:0] n);
      eff = a;
      eff[1:0] = strap ? a[1:0] ^ n : a[1:0] + n;
   endfunction : eff
   // lane bits written for active-low selects
   function automatic logic [35:0] lmask(input logic [3:0] ln);
      for (int i = 0; i < 4; i++) begin
         lmask[8*i+:8] = {8{!ln[i]}};
         lmask[32+i] = !ln[i];
      end
   endfunction : lmask
   // one edge of bus controls; checks what the previous edge produced
   task automatic beat(input logic [12:0] c, input logic [18:0] a, input logic [35:0] d,
         input logic [2:0] ex, input logic [35:0] ed);
      @(posedge sys_clk);
      {pStrobeN, cStrobeN, advN, sel1N, sel2, sel3N, gwN, bqN, laneN, oeN} <= c;
      hostDrive <= c[0];
      address <= a;
      hostData <= d;
      #1;
      if (pend[2]) check({34'h0, parOe, devOe}, {34'h0, pend[1], pend[1]});
      if (pend[0]) check(devOut, pendData);
      pend = ex;
      pendData = ed;
   endtask : beat
   initial begin
      logic [18:0] base;
      logic [35:0] d;
      logic [31:0] r;
      void'($urandom(43844));
      for (int s = 0; s < 2; s++) begin
         rst <= 1'b1;
         strap <= s[0];
         repeat (12) @(posedge sys_clk);
         rst <= 1'b0;
         #1 check({35'h0, qReady}, 36'h1);
         for (int it = 0; it < 8; it++) begin
            base = 19'($urandom);
            // global write burst under the controller strobe
            for (int b = 0; b < 4; b++) begin
               d = 36'({$urandom, $urandom});
               mem[eff(base, 2'(b))] = d;
               beat(ctl(1, b != 0, b == 0, 0, 1, 0, 0, 1, 4'hf, 1), base, d, 3'h4, d);
            end
            // byte write with random lanes
            d = 36'({$urandom, $urandom});
            r = $urandom;
            // at least one lane selected, else the edge is a read
            if (&r[3:0]) r[0] = 1'b0;
            mem[base] = (mem[base] & ~lmask(r[3:0])) | (d & lmask(r[3:0]));
            beat(ctl(1, 0, 1, 0, 1, 0, 1, 0, r[3:0], 1), base, d, 3'h4, d);
            repeat (10) beat(ctl(1, 0, 1, 0, 0, 0, 1, 1, 4'hf, 0), base, d, 3'h4, d);
            // read burst, first clock masked, then advancing
            r = $urandom;
            beat(ctl(0, r[3], 1, 0, 1, 0, 1, 1, 4'hf, 0), base, d, 3'h5, mem[base]);
            for (int b = 1; b < 4; b++) begin
               r = $urandom;
               d = mem[eff(base, 2'(b))];
               beat(ctl(1, 1, 0, r[0], r[1], r[2], 1, 1, 4'hf, 0), base, d, 3'h7, d);
            end
            // processor strobe with first select high, no advance
            beat(ctl(0, 1, 1, 1, r[4], r[5], 1, 1, 4'hf, 0), ~base, d, 3'h7, d);
            beat(ctl(1, 0, 1, 0, 0, 0, 1, 1, 4'hf, 0), base, d, 3'h4, d);
         end
      end
      finish_test();
   end
endmodule : sync_burst_sram_port_bench
